// file: mah_pkg.sv
// package: constants and types for the motor driver alarm handler
package mah_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_DEV_LIMIT = 8'h08;
	localparam logic [7:0] OFS_WARN_LIMIT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_HIST_CNT = 8'h18;
	localparam logic [7:0] OFS_HIST0 = 8'h40;
	localparam int HIST_DEPTH = 10;
	// command register bits (write one to act)
	localparam int CMD_SER_CLR = 0;
	localparam int CMD_SER_ABS_CLR = 1;
	localparam int CMD_TOOL_CLR = 2;
	localparam int CMD_TOOL_ABS_CLR = 3;
	localparam int CMD_HIST_CLR = 4;
	// status register fields
	localparam int ST_ACTIVE = 0;
	localparam int ST_ABS = 1;
	localparam int ST_WARN = 2;
	localparam int ST_CODE_LSB = 8;
	localparam int ST_BLINK_LSB = 16;
	// interrupt bits
	localparam int IRQ_RAISE = 0;
	localparam int IRQ_WARN = 1;
	localparam int IRQ_CLEAR = 2;
	localparam int IRQ_W = 3;
	// reset values
	localparam logic [15:0] DEV_LIMIT_RST = 16'hFFFF;
	localparam logic [15:0] WARN_LIMIT_RST = 16'hFFFF;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	// alarm codes and lamp blink counts
	localparam logic [7:0] CODE_POS_DEV = 8'h10;
	localparam logic [3:0] BLINK_POS_DEV = 4'h4;
	localparam logic [7:0] CODE_COFF_DEV = 8'h12;
	localparam logic [3:0] BLINK_COFF_DEV = 4'h4;
	localparam logic [7:0] CODE_ABS_POS = 8'h66;
	localparam logic [3:0] BLINK_ABS_POS = 4'h7;
	// lamp timing
	localparam int CLK_MHZ = 200;
	localparam int BLINK_ON_MS = 200;
	localparam int BLINK_OFF_MS = 200;
	localparam int BLINK_GAP_MS = 1000;
	localparam int BLINK_ON_CYC = BLINK_ON_MS * CLK_MHZ * 1000;
	localparam int BLINK_OFF_CYC = BLINK_OFF_MS * CLK_MHZ * 1000;
	localparam int BLINK_GAP_CYC = BLINK_GAP_MS * CLK_MHZ * 1000;
	// alarm request from a protective function
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [3:0] blinks;
	} mah_alarm_type;
	typedef enum {LAMP_IDLE, LAMP_ON, LAMP_OFF, LAMP_GAP} mah_lamp_type;
endpackage

// file: mah_alarm_handler.sv
// alarm handler: protective stop, lamp blink code, clears and history
//
// Overview of operation
// - any alarm drops the fault indicator and stops the motor
// - alarm lamp blinks repeatedly with an alarm specific count
// - falling edge of the fault clear input clears the alarm
// - serial alarm clear command clears the alarm
// - tool clear request or power cycling clears the alarm
// - position alarm clears only by its own input edge or command
// - generic clears and power cycling leave the position alarm set
// - keep up to ten alarm codes, newest first, oldest dropped
// - serial monitor read returns the stored history
// - serial maintenance clear erases the history
// - a warning is shown before the matching alarm is raised; the code makes only code 10h wait, 12h can rise together with warning_out
// - code 10h, four blinks, on deviation over limit with current on
// - code 12h when current on rises during current off deviation warning
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module mah_alarm_handler
	import mah_pkg::*;
#(
	parameter int BLINK_ON_CYCLES = BLINK_ON_CYC,
	parameter int BLINK_OFF_CYCLES = BLINK_OFF_CYC,
	parameter int BLINK_GAP_CYCLES = BLINK_GAP_CYC
)
(
	// clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic nvm_init_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// alarm sources
	input wire mah_alarm_type alarm_req,
	input wire logic abs_position_error_in,
	input wire logic [15:0] position_deviation,
	input wire logic current_on_in,
	input wire logic coff_dev_warn_in,
	// discrete inputs
	input wire logic fault_clear_in,
	input wire logic abs_position_error_clear_in,
	// outputs
	output logic fault_indicator_out,
	output logic motor_stop_out,
	output logic alarm_lamp_out,
	output logic warning_out,
	output logic irq
);
	// apb decode
	wire setup = psel & ~penable;
	wire wr_acc = psel & penable & pwrite;
	// full offset is range checked so high addresses do not alias
	wire [7:0] hist_ofs = paddr - OFS_HIST0;
	wire [3:0] hist_idx = hist_ofs[5:2];
	wire hist_hit = (paddr >= OFS_HIST0) && (hist_ofs[1:0] == 2'h0)
		&& (hist_ofs[7:6] == 2'h0) && (hist_idx < 4'(HIST_DEPTH));
	wire hit_cmd = (paddr == OFS_CMD);
	wire hit_stat = (paddr == OFS_STATUS);
	wire hit_dlim = (paddr == OFS_DEV_LIMIT);
	wire hit_wlim = (paddr == OFS_WARN_LIMIT);
	wire hit_istat = (paddr == OFS_IRQ_STAT);
	wire hit_imask = (paddr == OFS_IRQ_MASK);
	wire hit_hcnt = (paddr == OFS_HIST_CNT);
	wire mapped = hit_cmd | hit_stat | hit_dlim | hit_wlim | hit_istat
		| hit_imask | hit_hcnt | hist_hit;
	wire [4:0] cmd = (wr_acc & hit_cmd) ? pwdata[4:0] : 5'h00;

	logic [15:0] dev_limit_q;
	logic [15:0] warn_limit_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [31:0] prdata_q;
	logic gen_active_q;
	logic [7:0] gen_code_q;
	logic [3:0] gen_blinks_q;
	logic abs_active_q;
	logic [7:0] hist_q [HIST_DEPTH];
	logic [3:0] hist_cnt_q;
	logic fclr_prev_q;
	logic pclr_prev_q;
	logic con_prev_q;
	logic warn_q;

	// warning stage ahead of the deviation alarm
	wire dev_warn = position_deviation > warn_limit_q;
	wire warn_now = dev_warn | coff_dev_warn_in;
	// deviation alarm waits for the warning of the cycle before
	wire pos_dev_alarm = current_on_in & warn_q
		& (position_deviation > dev_limit_q);
	wire coff_alarm = current_on_in & ~con_prev_q
		& coff_dev_warn_in;

	// one source wins per cycle; the first alarm is held until cleared
	wire raise_gen = ~gen_active_q
		& (alarm_req.valid | pos_dev_alarm | coff_alarm);
	wire [7:0] raise_code = pos_dev_alarm ? CODE_POS_DEV
		: coff_alarm ? CODE_COFF_DEV : alarm_req.code;
	wire [3:0] raise_blinks = pos_dev_alarm ? BLINK_POS_DEV
		: coff_alarm ? BLINK_COFF_DEV : alarm_req.blinks;
	wire raise_abs = abs_position_error_in & ~abs_active_q;

	// clear paths
	wire fclr_fall = fclr_prev_q & ~fault_clear_in;
	wire pclr_fall = pclr_prev_q & ~abs_position_error_clear_in;
	wire gen_clear = fclr_fall | cmd[CMD_SER_CLR]
		| cmd[CMD_TOOL_CLR];
	wire abs_clear = pclr_fall | cmd[CMD_SER_ABS_CLR]
		| cmd[CMD_TOOL_ABS_CLR];
	wire any_active = gen_active_q | abs_active_q;

	// history push: one entry per cycle, position code over generic, raise beats erase
	wire push = raise_gen | raise_abs;
	wire [7:0] push_code = raise_abs ? CODE_ABS_POS : raise_code;
	wire hist_erase = cmd[CMD_HIST_CLR];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fclr_prev_q <= 1'b0;
			pclr_prev_q <= 1'b0;
			con_prev_q <= 1'b0;
			warn_q <= 1'b0;
		end
		else
		begin
			fclr_prev_q <= fault_clear_in;
			pclr_prev_q <= abs_position_error_clear_in;
			con_prev_q <= current_on_in;
			warn_q <= warn_now;
		end
	end

	// generic alarm is volatile: power cycling clears it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gen_active_q <= 1'b0;
			gen_code_q <= 8'h00;
			gen_blinks_q <= 4'h0;
		end
		else if (raise_gen)
		begin
			gen_active_q <= 1'b1;
			gen_code_q <= raise_code;
			gen_blinks_q <= raise_blinks;
		end
		else if (gen_clear)
			gen_active_q <= 1'b0;
	end

	// position alarm and history are kept across power cycles; of the two
	// resets, only the storage initialisation reset clears them
	always_ff @(posedge pclk or negedge nvm_init_n)
	begin
		if (!nvm_init_n)
			abs_active_q <= 1'b0;
		else if (raise_abs)
			abs_active_q <= 1'b1;
		else if (abs_clear)
			abs_active_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge nvm_init_n)
	begin
		if (!nvm_init_n)
		begin
			hist_cnt_q <= 4'h0;
			for (int i = 0; i < HIST_DEPTH; i++)
				hist_q[i] <= 8'h00;
		end
		else if (push)
		begin
			hist_q[0] <= push_code;
			for (int i = 1; i < HIST_DEPTH; i++)
				hist_q[i] <= hist_erase ? 8'h00 : hist_q[i-1];
			if (hist_erase)
				hist_cnt_q <= 4'h1;
			else if (hist_cnt_q < 4'(HIST_DEPTH))
				hist_cnt_q <= hist_cnt_q + 4'h1;
		end
		else if (hist_erase)
		begin
			hist_cnt_q <= 4'h0;
			for (int i = 0; i < HIST_DEPTH; i++)
				hist_q[i] <= 8'h00;
		end
	end

	// outputs of the protective stop
	assign fault_indicator_out = ~any_active;
	assign motor_stop_out = any_active;
	assign warning_out = warn_q;

	// lamp blink sequencer: n pulses, then a long gap, repeated
	wire [3:0] cur_blinks = abs_active_q ? BLINK_ABS_POS : gen_blinks_q;
	wire [7:0] cur_code = abs_active_q ? CODE_ABS_POS : gen_code_q;
	mah_lamp_type lamp_q;
	logic [31:0] lamp_cnt_q;
	logic [3:0] lamp_left_q;
	logic lamp_q_out;
	wire lamp_tick = (lamp_cnt_q == 32'h0);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lamp_q <= LAMP_IDLE;
			lamp_cnt_q <= 32'h0;
			lamp_left_q <= 4'h0;
			lamp_q_out <= 1'b0;
		end
		else if (!any_active)
		begin
			lamp_q <= LAMP_IDLE;
			lamp_q_out <= 1'b0;
		end
		else
		begin
			if (!lamp_tick)
				lamp_cnt_q <= lamp_cnt_q - 32'h1;
			unique case (lamp_q)
				LAMP_IDLE, LAMP_GAP:
					if (lamp_q == LAMP_IDLE || lamp_tick)
					begin
						lamp_q <= LAMP_ON;
						lamp_q_out <= 1'b1;
						lamp_left_q <= cur_blinks - 4'h1;
						lamp_cnt_q <= 32'(BLINK_ON_CYCLES - 1);
					end
				LAMP_ON:
					if (lamp_tick)
					begin
						lamp_q_out <= 1'b0;
						lamp_q <= (lamp_left_q == 4'h0) ? LAMP_GAP : LAMP_OFF;
						lamp_cnt_q <= (lamp_left_q == 4'h0)
							? 32'(BLINK_GAP_CYCLES - 1)
							: 32'(BLINK_OFF_CYCLES - 1);
					end
				LAMP_OFF:
					if (lamp_tick)
					begin
						lamp_q <= LAMP_ON;
						lamp_q_out <= 1'b1;
						lamp_left_q <= lamp_left_q - 4'h1;
						lamp_cnt_q <= 32'(BLINK_ON_CYCLES - 1);
					end
			endcase
		end
	end
	assign alarm_lamp_out = lamp_q_out;

	// interrupt status: hardware set beats a write-one clear
	wire [IRQ_W-1:0] irq_set = {gen_clear & gen_active_q
		| abs_clear & abs_active_q, warn_now & ~warn_q, push};
	wire [IRQ_W-1:0] irq_w1c = (wr_acc & hit_istat)
		? pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
	assign irq = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dev_limit_q <= DEV_LIMIT_RST;
			warn_limit_q <= WARN_LIMIT_RST;
			irq_stat_q <= {IRQ_W{1'b0}};
			irq_mask_q <= IRQ_MASK_RST;
		end
		else
		begin
			irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_set;
			if (wr_acc & hit_dlim)
				dev_limit_q <= pwdata[15:0];
			if (wr_acc & hit_wlim)
				warn_limit_q <= pwdata[15:0];
			if (wr_acc & hit_imask)
				irq_mask_q <= pwdata[IRQ_W-1:0];
		end
	end

	// read data is captured in the setup cycle
	wire [31:0] stat_word = {12'h000, cur_blinks, cur_code, 5'h00,
		warn_q, abs_active_q, any_active};
	wire [31:0] rd_mux = hit_stat ? stat_word
		: hit_dlim ? {16'h0000, dev_limit_q}
		: hit_wlim ? {16'h0000, warn_limit_q}
		: hit_istat ? {29'h0, irq_stat_q}
		: hit_imask ? {29'h0, irq_mask_q}
		: hit_hcnt ? {28'h0, hist_cnt_q}
		: hist_hit ? {24'h0, hist_q[hist_idx]}
		: 32'h0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0;
		else if (setup & ~pwrite)
			prdata_q <= rd_mux;
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
endmodule

// file: mah_alarm_handler_sva.sv
// checker: port level timing of raise, clear, lamp and warning
`timescale 1ns/100ps
module mah_alarm_sva
	import mah_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// causes
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire mah_alarm_type alarm_req,
	input wire logic abs_position_error_in,
	input wire logic current_on_in,
	input wire logic coff_dev_warn_in,
	input wire logic fault_clear_in,
	input wire logic abs_position_error_clear_in,
	// effects
	input wire logic fault_indicator_out,
	input wire logic motor_stop_out,
	input wire logic alarm_lamp_out,
	input wire logic warning_out
);
	logic fc_q;
	logic pc_q;
	logic [2:0] cz_q;
	wire logic cause_now;
	// any write may be a clear command; the bus data is not decoded here
	assign cause_now = (psel & penable & pwrite) | (fc_q & ~fault_clear_in)
		| (pc_q & ~abs_position_error_clear_in);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			fc_q <= 1'b0;
			pc_q <= 1'b0;
			cz_q <= 3'h0;
		end
		else
		begin
			fc_q <= fault_clear_in;
			pc_q <= abs_position_error_clear_in;
			cz_q <= {cz_q[1:0], cause_now};
		end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_raise_drops_fault: assert property
		(alarm_req.valid && fault_indicator_out |=> !fault_indicator_out)
		else $error("fault output stayed high after a raise");
	a_stop_tracks_fault: assert property
		(motor_stop_out != fault_indicator_out)
		else $error("motor stop disagrees with fault output");
	a_lamp_starts_on: assert property
		($fell(fault_indicator_out) |=> alarm_lamp_out)
		else $error("lamp did not light after a raise");
	a_lamp_dark_idle: assert property
		(fault_indicator_out[*4] |-> !alarm_lamp_out)
		else $error("lamp lit with no alarm");
	a_clear_has_cause: assert property
		($rose(fault_indicator_out) |-> |cz_q)
		else $error("alarm cleared without a clear event");
	a_abs_raises: assert property
		(abs_position_error_in |=> !fault_indicator_out)
		else $error("position error did not raise an alarm");
	a_coff_on_raises: assert property
		($rose(current_on_in) && coff_dev_warn_in |=> !fault_indicator_out)
		else $error("current on during warning did not raise");
	a_warn_follows: assert property
		(coff_dev_warn_in |=> warning_out)
		else $error("warning output missing");
endmodule
bind mah_alarm_handler mah_alarm_sva sva_u (.pclk, .presetn, .psel,
	.penable, .pwrite, .alarm_req, .abs_position_error_in, .current_on_in,
	.coff_dev_warn_in, .fault_clear_in, .abs_position_error_clear_in,
	.fault_indicator_out, .motor_stop_out, .alarm_lamp_out, .warning_out);

// file: mah_host.sv
// host model: drives the two discrete clear inputs
`timescale 1ns/100ps
module mah_host
(
	// clock
	input wire logic pclk,
	// clear inputs
	output logic fault_clear_in,
	output logic abs_position_error_clear_in
);
	initial
	begin
		fault_clear_in = 1'b0;
		abs_position_error_clear_in = 1'b0;
	end
	// held on for a while, the device acts on the release
	task pulse(input bit p);
		if (p)
			abs_position_error_clear_in <= 1'b1;
		else
			fault_clear_in <= 1'b1;
		repeat (3) @(posedge pclk);
		fault_clear_in <= 1'b0;
		abs_position_error_clear_in <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
endmodule

// file: tb.sv
// testbench: alarm handler over apb and discrete inputs
`timescale 1ns/100ps
module tb
	import mah_pkg::*;
;
	logic pclk = 0, presetn = 0, nvm_init_n = 0;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 0, c;
	logic [3:0] b;
	logic [31:0] pwdata = 0, prdata;
	mah_alarm_type alarm_req = '0;
	logic abs_position_error_in = 0, current_on_in = 0, coff_dev_warn_in = 0;
	logic [15:0] position_deviation = 0;
	logic fault_clear_in, abs_position_error_clear_in, irq, lp;
	logic fault_indicator_out, motor_stop_out, alarm_lamp_out, warning_out;
	logic [32:0] nq[$], mq[$];
	int failures = 0, compares = 0, cyc = 0, k, i, seed = 32'h3BABD306;
	always #2.5 pclk = ~pclk;
	mah_alarm_handler #(.BLINK_ON_CYCLES(4), .BLINK_OFF_CYCLES(4),
		.BLINK_GAP_CYCLES(10)) dut_u (.pclk, .presetn, .nvm_init_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.alarm_req, .abs_position_error_in, .position_deviation,
		.current_on_in, .coff_dev_warn_in, .fault_clear_in,
		.abs_position_error_clear_in, .fault_indicator_out, .motor_stop_out,
		.alarm_lamp_out, .warning_out, .irq);
	mah_host host_u (.pclk, .fault_clear_in, .abs_position_error_clear_in);
	task chk(string n, logic [32:0] s, logic [32:0] e);
		compares++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task final_report;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task bus(logic w, logic [7:0] a, logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task wr(logic [7:0] a, logic [31:0] d);
		bus(1, a, d);
	endtask
	// bit 32 of a note stands for the error response
	task rd(logic [7:0] a, logic [31:0] m, logic [32:0] e);
		mq.push_back({1'b1, m});
		nq.push_back(e);
		bus(0, a, 0);
	endtask
	always @(posedge pclk)
		if (psel && penable && !pwrite && pready === 1'b1 && mq.size() > 0)
			chk("read", {pslverr, prdata} & mq.pop_front(), nq.pop_front());
	task raise(logic [7:0] rc);
		alarm_req <= {1'b1, rc, 4'h1};
		@(posedge pclk);
		alarm_req.valid <= 0;
		repeat (2) @(posedge pclk);
	endtask
	task gclr(int m);
		case (m)
			0: host_u.pulse(0);
			1: wr(OFS_CMD, 32'h1 << CMD_SER_CLR);
			2: wr(OFS_CMD, 32'h1 << CMD_TOOL_CLR);
			default:
			begin
				presetn <= 0;
				@(posedge pclk);
				presetn <= 1;
			end
		endcase
		repeat (2) @(posedge pclk);
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			final_report;
		end
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		nvm_init_n <= 1;
		@(posedge pclk);
		rd(OFS_DEV_LIMIT, '1, DEV_LIMIT_RST);
		rd(OFS_WARN_LIMIT, '1, WARN_LIMIT_RST);
		rd(OFS_IRQ_MASK, '1, IRQ_MASK_RST);
		rd(8'h30, '1, 33'h100000000);
		wr(OFS_IRQ_MASK, 32'h1);
		c = 8'($random(seed));
		b = 4'(1 + {$random(seed)} % 7);
		alarm_req <= {1'b1, c, b};
		@(posedge pclk);
		alarm_req.valid <= 0;
		k = 0;
		lp = 0;
		repeat (b * 8 + 5)
		begin
			@(negedge pclk);
			k += (alarm_lamp_out === 1'b1 && lp !== 1'b1);
			lp = alarm_lamp_out;
		end
		chk("blinks", k, b);
		chk("stop", motor_stop_out, 1);
		chk("irq", irq, 1);
		@(posedge pclk);
		raise(~c);
		rd(OFS_HIST_CNT, '1, 1);
		rd(OFS_HIST0, 32'hFF, c);
		rd(OFS_STATUS, 32'hFFF00, {b, c, 8'h0});
		wr(OFS_IRQ_STAT, 32'h1);
		chk("irq", irq, 0);
		for (i = 0; i < 4; i++)
		begin
			if (i > 0)
				raise(8'h20);
			gclr(i);
			chk("cleared", fault_indicator_out, 1);
		end
		abs_position_error_in <= 1;
		@(posedge pclk);
		abs_position_error_in <= 0;
		for (i = 0; i < 4; i++)
			gclr(i);
		chk("abs held", fault_indicator_out, 0);
		rd(OFS_STATUS, 32'h2, 32'h2);
		host_u.pulse(1);
		chk("abs clr", fault_indicator_out, 1);
		for (i = CMD_SER_ABS_CLR; i <= CMD_TOOL_ABS_CLR; i += 2)
		begin
			abs_position_error_in <= 1;
			@(posedge pclk);
			abs_position_error_in <= 0;
			wr(OFS_CMD, 32'h1 << i);
			repeat (2) @(posedge pclk);
			chk("abs cmd", fault_indicator_out, 1);
		end
		coff_dev_warn_in <= 1;
		repeat (2) @(posedge pclk);
		chk("warn", {warning_out, fault_indicator_out}, 2'b11);
		current_on_in <= 1;
		repeat (2) @(posedge pclk);
		rd(OFS_STATUS, 32'hFF00, {CODE_COFF_DEV, 8'h0});
		rd(OFS_IRQ_STAT, '1, 33'h7);
		coff_dev_warn_in <= 0;
		current_on_in <= 0;
		gclr(0);
		wr(OFS_DEV_LIMIT, 32'h64);
		wr(OFS_WARN_LIMIT, 32'h32);
		current_on_in <= 1;
		position_deviation <= 16'h50;
		repeat (3) @(posedge pclk);
		chk("warn", {warning_out, fault_indicator_out}, 2'b11);
		position_deviation <= 16'hC8;
		repeat (3) @(posedge pclk);
		rd(OFS_STATUS, 32'hFFF00, {BLINK_POS_DEV, CODE_POS_DEV, 8'h0});
		position_deviation <= 0;
		current_on_in <= 0;
		gclr(1);
		wr(OFS_CMD, 32'h1 << CMD_HIST_CLR);
		rd(OFS_HIST_CNT, '1, 0);
		for (i = 0; i < 11; i++)
		begin
			raise(8'h30 + 8'(i));
			gclr(2);
		end
		rd(OFS_HIST_CNT, '1, HIST_DEPTH);
		rd(OFS_HIST0, 32'hFF, 8'h3A);
		rd(OFS_HIST0 + 8'h24, 32'hFF, 8'h31);
		rd(8'h80, '1, 33'h100000000);
		final_report;
	end
endmodule
